// ===== rtl/sph_core.sv
// Behaviour
// - frame: delimiter, address, command code, settings, end character(s)
// - module commands start with the dollar delimiter
// - address is two hex characters, 00 to FF
// - command code of one or two characters follows the address
// - with checksum on, two hex checksum characters precede the end
// - host frame end follows the configured terminator_select
// - first port answers to module address, port k to address plus k
// - pass-through payload and end character go to the addressed port
// - device data buffered per port; read one port or all ports
// - default mode keeps every unread record until the buffer fills
// - latest mode keeps only the newest record
// - prefix option puts the source port address before each message
// - reading an empty buffer gives no response, except UR, which answers N/A
`timescale 1ns/1ps
module sph_core
  import sph_pkg::*;
#(
  parameter int unsigned GAP_CYC = sph_pkg::FRAME_GAP_CYC
) (
  input  wire logic                              clock,
  input  wire logic                              rst,
  input  wire logic [sph_pkg::REG_AW-1:0]        reg_addr,
  input  wire logic [7:0]                        reg_wdata,
  input  wire logic                              reg_we,
  input  wire logic                              reg_re,
  output logic      [7:0]                        reg_rdata,
  input  wire logic [7:0]                        host_rx_data,
  input  wire logic                              host_rx_valid,
  output logic                                   host_rx_ready,
  output logic      [7:0]                        host_tx_data,
  output logic                                   host_tx_valid,
  input  wire logic                              host_tx_ready,
  input  wire logic [sph_pkg::NPORT-1:0][7:0]    dev_rx_data,
  input  wire logic [sph_pkg::NPORT-1:0]         dev_rx_valid,
  output logic      [sph_pkg::NPORT-1:0]         dev_rx_ready,
  output logic      [7:0]                        dev_tx_data,
  output logic      [sph_pkg::PORT_W-1:0]        dev_tx_port,
  output logic                                   dev_tx_valid,
  input  wire logic                              dev_tx_ready
);
  import sph_pkg::*;

  typedef enum logic [2:0] {P_IDLE, P_AH, P_AL, P_BODY, P_SKIP} sph_pst_e;
  typedef enum logic [3:0] {T_IDLE, T_SEL, T_PH, T_PL, T_DATA, T_NA, T_T1, T_T2} sph_tst_e;

  typedef struct packed {
    sph_pst_e                   pst;
    logic                       pass;
    logic [3:0]                 ahi;
    logic [PORT_W-1:0]          port;
    logic [7:0]                 sum;
    logic [3:0][7:0]            last;
    logic [2:0]                 nb;
    logic [GAP_W-1:0]           gap;
    sph_tst_e                   tst;
    logic [PORT_W-1:0]          tport;
    logic                       tall;
    logic [1:0]                 tna;
    logic [7:0]                 hdata;
    logic                       hval;
    logic [7:0]                 ddata;
    logic [PORT_W-1:0]          dport;
    logic                       dval;
    logic [7:0]                 maddr;
    logic [CFG_W-1:0]           cfg;
    logic [7:0]                 pdelim;
    logic [7:0]                 rdata;
    logic [7:0]                 drops;
    logic [NPORT-1:0]           mid;
    logic [NPORT-1:0][CNT_W-1:0] rcnt;
  } sph_core_s;

  sph_core_s                     s;
  sph_core_s                     n;
  logic [NPORT-1:0][WORD_W-1:0]  f_in;
  logic [NPORT-1:0]              f_wr;
  logic [NPORT-1:0]              f_rdy;
  logic [NPORT-1:0]              f_clr;
  logic [NPORT-1:0][WORD_W-1:0]  f_out;
  logic [NPORT-1:0]              f_ov;
  logic [NPORT-1:0]              f_pop;
  logic [NPORT-1:0]              nonempty;

  function automatic logic is_hex(input logic [7:0] c);
    logic [7:0] l;
    l = c | 8'h20;
    return (c >= 8'h30 && c <= 8'h39) || (l >= 8'h61 && l <= 8'h66);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction

  function automatic logic [PORT_W-1:0] first_set(input logic [NPORT-1:0] v);
    logic [PORT_W-1:0] r;
    r = '0;
    for (int i = NPORT - 1; i >= 0; i--)
    begin
      if (v[i])
        r = PORT_W'(i);
    end
    return r;
  endfunction

  // one buffer per device port
  for (genvar p = 0; p < NPORT; p++)
  begin : g_buf
    sph_fifo #(
      .W     (WORD_W),
      .DEPTH (BUF_DEPTH)
    ) u_buf (
      .clock     (clock),
      .rst       (rst),
      .clear     (f_clr[p]),
      .in_data   (f_in[p]),
      .in_valid  (f_wr[p]),
      .in_ready  (f_rdy[p]),
      .out_data  (f_out[p]),
      .out_valid (f_ov[p]),
      .out_ready (f_pop[p])
    );
    assign nonempty[p] = (s.rcnt[p] != '0);
  end

  assign reg_rdata     = s.rdata;
  assign host_tx_data  = s.hdata;
  assign host_tx_valid = s.hval;
  assign dev_tx_data   = s.ddata;
  assign dev_tx_port   = s.dport;
  assign dev_tx_valid  = s.dval;
  // half duplex: no intake while a reply is going out
  assign host_rx_ready = !s.dval && !s.hval && (s.tst == T_IDLE);

  logic [1:0]        tsel;
  logic              ck_en;
  logic              take;
  logic              is_term;
  logic              gap_hit;
  logic              fend;
  logic              ck_ok;
  logic [7:0]        ck_sum;
  logic [7:0]        paddr;
  logic [7:0]        diff;
  logic [2:0]        ncmd;
  logic [7:0]        c1;
  logic [7:0]        c2;
  logic              step;
  logic              tnext;
  logic              isend;
  logic              skip;
  logic              flush;
  logic [NPORT-1:0]  inc;
  logic [NPORT-1:0]  dec;

  always_comb
  begin
    n       = s;
    tsel    = s.cfg[CFG_TSEL +: 2];
    ck_en   = s.cfg[CFG_CKSUM];
    n.rdata = '0;
    f_pop   = '0;
    inc     = '0;
    dec     = '0;
    tnext   = 1'b0;

    // register port; read data stand only in the next cycle
    if (reg_we)
    begin
      case (reg_addr)
        REG_MADDR:  n.maddr  = reg_wdata;
        REG_CFG:    n.cfg    = reg_wdata[CFG_W-1:0];
        REG_PDELIM: n.pdelim = reg_wdata;
        default:    n.maddr  = s.maddr;
      endcase
    end
    if (reg_re)
    begin
      case (reg_addr)
        REG_MADDR:  n.rdata = s.maddr;
        REG_CFG:    n.rdata = {2'h0, s.cfg};
        REG_PDELIM: n.rdata = s.pdelim;
        REG_STATUS: n.rdata = {1'b0, nonempty};
        REG_DROPS:  n.rdata = s.drops;
        default:    n.rdata = '0;
      endcase
    end

    if (dev_tx_ready)
      n.dval = 1'b0;
    if (host_tx_ready)
      n.hval = 1'b0;

    // frame end detection
    take = host_rx_valid && host_rx_ready;
    case (tsel)
      TS_CR:   is_term = (host_rx_data == CH_CR);
      TS_CRLF: is_term = (host_rx_data == CH_LF);
      TS_LF:   is_term = (host_rx_data == CH_LF);
      default: is_term = 1'b0;
    endcase
    gap_hit = (tsel == TS_NONE) && (s.pst != P_IDLE) && (s.gap == GAP_W'(GAP_CYC - 1));
    n.gap   = (take || s.pst == P_IDLE) ? '0 : s.gap + GAP_W'(1);
    fend    = (take && is_term && s.pst != P_IDLE) || gap_hit;

    // checksum covers all characters ahead of the two checksum characters
    ck_sum = s.sum - s.last[0] - s.last[1];
    ck_ok  = !ck_en || ((s.nb >= 3'd2) && is_hex(s.last[1]) && is_hex(s.last[0])
             && (ck_sum == {hex_val(s.last[1]), hex_val(s.last[0])}));
    ncmd   = ck_en ? s.nb - 3'd2 : s.nb;
    c1     = ck_en ? s.last[3] : s.last[1];
    c2     = ck_en ? s.last[2] : s.last[0];
    if (ncmd == 3'd1)
      c1 = c2;
    diff   = {s.ahi, hex_val(host_rx_data)} - s.maddr;
    paddr  = s.maddr + {5'h0, s.tport};

    // frame parser
    if (fend)
    begin
      n.pst = P_IDLE;
      if (s.pst != P_BODY || !ck_ok)
        n.drops = s.drops + 8'h01;
      else if (s.pass)
      begin
        if (take)
        begin
          n.dval  = 1'b1;
          n.ddata = host_rx_data;
          n.dport = s.port;
        end
      end
      else if (ncmd == 3'd1 && c1 == CH_U)
      begin
        if (s.rcnt[s.port] != '0)
        begin
          n.tport = s.port;
          n.tall  = 1'b0;
          n.tst   = T_SEL;
        end
      end
      else if (ncmd == 3'd2 && c1 == CH_U && c2 == CH_R)
      begin
        n.tport = s.port;
        n.tall  = 1'b0;
        n.tna   = '0;
        n.tst   = (s.rcnt[s.port] != '0) ? T_SEL : T_NA;
      end
      else if (ncmd == 3'd2 && c1 == CH_U && c2 == CH_A)
      begin
        n.tport = '0;
        n.tall  = 1'b1;
        n.tst   = T_SEL;
      end
      else
        n.drops = s.drops + 8'h01;
    end
    else if (take && !(tsel == TS_CRLF && host_rx_data == CH_CR))
    begin
      case (s.pst)
        P_IDLE:
        begin
          if (host_rx_data == CH_DOLLAR || host_rx_data == s.pdelim)
          begin
            n.pass = (host_rx_data != CH_DOLLAR);
            n.sum  = host_rx_data;
            n.nb   = '0;
            n.pst  = P_AH;
          end
        end
        P_AH:
        begin
          n.ahi = hex_val(host_rx_data);
          n.sum = s.sum + host_rx_data;
          n.pst = is_hex(host_rx_data) ? P_AL : P_SKIP;
        end
        P_AL:
        begin
          n.sum  = s.sum + host_rx_data;
          n.port = diff[PORT_W-1:0];
          if (is_hex(host_rx_data) && diff < 8'(NPORT))
            n.pst = P_BODY;
          else
            n.pst = P_SKIP;
        end
        P_BODY:
        begin
          n.sum  = s.sum + host_rx_data;
          n.last = {s.last[2:0], host_rx_data};
          n.nb   = (s.nb == 3'd5) ? s.nb : s.nb + 3'd1;
          // with checksum on, payload trails two characters behind so checksum stays local
          if (s.pass && (!ck_en || s.nb >= 3'd2))
          begin
            n.dval  = 1'b1;
            n.ddata = ck_en ? s.last[1] : host_rx_data;
            n.dport = s.port;
          end
        end
        default: n.pst = s.pst;
      endcase
    end

    // reply and forwarding sequencer
    step = !s.hval || host_tx_ready;
    case (s.tst)
      T_IDLE:
      begin
        if (s.cfg[CFG_FWD] && s.pst == P_IDLE && |nonempty)
        begin
          n.tport = first_set(nonempty);
          n.tall  = 1'b0;
          n.tst   = T_SEL;
        end
      end
      T_SEL:
      begin
        if (s.rcnt[s.tport] != '0)
          n.tst = s.cfg[CFG_PREFIX] ? T_PH : T_DATA;
        else if (s.tall && s.tport != PORT_W'(NPORT - 1))
          n.tport = s.tport + PORT_W'(1);
        else
          n.tst = T_IDLE;
      end
      T_PH:
      begin
        if (step)
        begin
          n.hval  = 1'b1;
          n.hdata = hex_chr(paddr[7:4]);
          n.tst   = T_PL;
        end
      end
      T_PL:
      begin
        if (step)
        begin
          n.hval  = 1'b1;
          n.hdata = hex_chr(paddr[3:0]);
          n.tst   = T_DATA;
        end
      end
      T_DATA:
      begin
        if (step && f_ov[s.tport])
        begin
          f_pop[s.tport] = 1'b1;
          if (f_out[s.tport][WORD_W-1])
          begin
            dec[s.tport] = 1'b1;
            n.tst        = T_T1;
          end
          else
          begin
            n.hval  = 1'b1;
            n.hdata = f_out[s.tport][7:0];
          end
        end
      end
      T_NA:
      begin
        if (step)
        begin
          n.hval  = 1'b1;
          n.hdata = (s.tna == 2'd0) ? CH_N : (s.tna == 2'd1) ? CH_SLASH : CH_A;
          n.tna   = s.tna + 2'd1;
          if (s.tna == 2'd2)
            n.tst = T_T1;
        end
      end
      T_T1:
      begin
        if (step)
        begin
          n.hval  = (tsel != TS_NONE);
          n.hdata = (tsel == TS_LF) ? CH_LF : CH_CR;
          if (tsel == TS_CRLF)
            n.tst = T_T2;
          else
            tnext = 1'b1;
        end
      end
      T_T2:
      begin
        if (step)
        begin
          n.hval  = 1'b1;
          n.hdata = CH_LF;
          tnext   = 1'b1;
        end
      end
      default: n.tst = T_IDLE;
    endcase
    if (tnext)
    begin
      if (s.tall && s.tport != PORT_W'(NPORT - 1))
      begin
        n.tport = s.tport + PORT_W'(1);
        n.tst   = T_SEL;
      end
      else
        n.tst = T_IDLE;
    end

    // device receive side: records end on CR or LF; a lone end is dropped
    for (int p = 0; p < NPORT; p++)
    begin
      isend   = (dev_rx_data[p] == CH_CR) || (dev_rx_data[p] == CH_LF);
      skip    = isend && !s.mid[p];
      flush   = s.cfg[CFG_LATEST] && dev_rx_valid[p] && !isend && !s.mid[p]
                && (s.rcnt[p] != '0) && !(s.tst != T_IDLE && s.tport == PORT_W'(p));
      f_clr[p] = flush;
      f_in[p]  = {isend, dev_rx_data[p]};
      f_wr[p]  = dev_rx_valid[p] && !skip;
      // full buffer stalls the device stream rather than losing data
      dev_rx_ready[p] = skip || f_rdy[p];
      if (dev_rx_valid[p] && f_rdy[p] && !skip)
      begin
        n.mid[p] = !isend;
        inc[p]   = isend;
      end
      if (flush)
        n.rcnt[p] = '0;
      else
        n.rcnt[p] = s.rcnt[p] + CNT_W'(inc[p]) - CNT_W'(dec[p]);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s        <= '0;
      s.pst    <= P_IDLE;
      s.tst    <= T_IDLE;
      s.maddr  <= MADDR_RST;
      s.cfg    <= CFG_RST;
      s.pdelim <= PDELIM_RST;
    end
    else
      s <= n;
  end
endmodule

// ===== rtl/sph_fifo.sv
`timescale 1ns/1ps
module sph_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic [W-1:0]            dout;
  } sph_fifo_s;

  sph_fifo_s s;
  sph_fifo_s n;
  logic      push;
  logic      pop;

  // clear frees the whole buffer, so a write in the same cycle is taken
  assign in_ready  = (s.cnt != (AW+1)'(DEPTH)) || clear;
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.dout;

  // pointer and head update; head word is re-read into a register
  always_comb
  begin
    n    = s;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready && !clear;
    if (clear)
    begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end
    if (push)
    begin
      n.mem[n.wp] = in_data;
      n.wp        = n.wp + AW'(1);
      n.cnt       = n.cnt + (AW+1)'(1);
    end
    if (pop)
    begin
      n.rp  = n.rp + AW'(1);
      n.cnt = n.cnt - (AW+1)'(1);
    end
    n.dout = n.mem[n.rp]; // bypass when head is written this cycle
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      s <= '0;
    else
      s <= n;
  end
endmodule

// ===== rtl/sph_pkg.sv
package sph_pkg;
  // geometry
  localparam int NPORT      = 7;
  localparam int PORT_W     = 3;
  localparam int BUF_DEPTH  = 16;
  localparam int WORD_W     = 9;
  localparam int CNT_W      = 5;
  localparam int REG_AW     = 3;

  // register offsets
  localparam logic [REG_AW-1:0] REG_MADDR  = 3'h0;
  localparam logic [REG_AW-1:0] REG_CFG    = 3'h1;
  localparam logic [REG_AW-1:0] REG_PDELIM = 3'h2;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h3;
  localparam logic [REG_AW-1:0] REG_DROPS  = 3'h4;

  // config field positions
  localparam int CFG_CKSUM  = 0;
  localparam int CFG_TSEL   = 1;
  localparam int CFG_LATEST = 3;
  localparam int CFG_PREFIX = 4;
  localparam int CFG_FWD    = 5;
  localparam int CFG_W      = 6;

  // reset values
  localparam logic [7:0]       MADDR_RST  = 8'h01;
  localparam logic [CFG_W-1:0] CFG_RST    = 6'h00;
  localparam logic [7:0]       PDELIM_RST = 8'h3a;

  // terminator_select codes
  localparam logic [1:0] TS_CR   = 2'h0;
  localparam logic [1:0] TS_CRLF = 2'h1;
  localparam logic [1:0] TS_LF   = 2'h2;
  localparam logic [1:0] TS_NONE = 2'h3;

  // characters
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_U      = 8'h55;
  localparam logic [7:0] CH_R      = 8'h52;
  localparam logic [7:0] CH_A      = 8'h41;
  localparam logic [7:0] CH_N      = 8'h4e;
  localparam logic [7:0] CH_SLASH  = 8'h2f;

  // idle gap that closes a frame when no end character is used
  localparam int FRAME_GAP_US  = 1000;
  localparam int CLK_FREQ_MHZ  = 40;
  localparam int FRAME_GAP_CYC = FRAME_GAP_US * CLK_FREQ_MHZ;
  localparam int GAP_W         = 16;
endpackage

// ===== verification/sph_core_checker.sv
`timescale 1ns/1ps
module sph_core_checker
  import sph_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       rst,
  input wire logic [sph_pkg::REG_AW-1:0] reg_addr,
  input wire logic                       reg_re,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       host_rx_valid,
  input wire logic                       host_rx_ready,
  input wire logic [7:0]                 host_tx_data,
  input wire logic                       host_tx_valid,
  input wire logic                       host_tx_ready,
  input wire logic [7:0]                 dev_tx_data,
  input wire logic [sph_pkg::PORT_W-1:0] dev_tx_port,
  input wire logic                       dev_tx_valid,
  input wire logic                       dev_tx_ready
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // read data shows only in the cycle after a strobe, zero elsewhere
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (reg_re && reg_addr > REG_DROPS |=> reg_rdata == 8'h00)
    else $error("unmapped register read not zero");
  // outputs leave reset quiet and ready to listen
  a_quiet_reset: assert property ($past(rst) |-> !host_tx_valid && !dev_tx_valid && host_rx_ready)
    else $error("outputs busy right after reset");
  // reply bytes are held until the host takes them
  a_reply_hold: assert property (host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_data))
    else $error("reply byte dropped or changed while stalled");
  // pass-through bytes and their port are held through a device stall
  a_pass_hold: assert property (dev_tx_valid && !dev_tx_ready |=> dev_tx_valid && $stable({dev_tx_port, dev_tx_data}))
    else $error("pass-through byte changed while stalled");
  a_port_range: assert property (dev_tx_valid |-> dev_tx_port < 3'h7)
    else $error("pass-through aimed at a port that does not exist");
  // a pass-through byte only ever follows a host byte being taken
  a_pass_cause: assert property ($rose(dev_tx_valid) |-> $past(host_rx_valid && host_rx_ready))
    else $error("pass-through byte without a host byte before it");
  // the host input is shut while anything goes out
  a_pass_blocks_rx: assert property (dev_tx_valid |-> !host_rx_ready)
    else $error("host input open during pass-through");
  a_reply_blocks_rx: assert property (host_tx_valid |-> !host_rx_ready)
    else $error("host input open during a reply");
endmodule

bind sph_core sph_core_checker u_chk (
  .clock         (clock),
  .rst           (rst),
  .reg_addr      (reg_addr),
  .reg_re        (reg_re),
  .reg_rdata     (reg_rdata),
  .host_rx_valid (host_rx_valid),
  .host_rx_ready (host_rx_ready),
  .host_tx_data  (host_tx_data),
  .host_tx_valid (host_tx_valid),
  .host_tx_ready (host_tx_ready),
  .dev_tx_data   (dev_tx_data),
  .dev_tx_port   (dev_tx_port),
  .dev_tx_valid  (dev_tx_valid),
  .dev_tx_ready  (dev_tx_ready)
);

// ===== verification/sph_host_model.sv
`timescale 1ns/1ps
module sph_host_model (
  input  wire logic       clock,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] got_q[$];
  logic       slow = 1'b0;

  // bus idle at start
  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end

  // whole frame, one byte held until taken, framing built by the caller
  task automatic send(input string f);
    foreach (f[i])
    begin
      rx_data  <= f[i];
      rx_valid <= 1'b1;
      do @(negedge clock); while (!rx_ready);
      @(posedge clock);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~f[f.len()-1]; // released line must not look like the last byte
    @(posedge clock);
  endtask

  // listener; slow mode stalls every other cycle, never talks while forwarding
  always @(posedge clock)
  begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready)
      got_q.push_back(tx_data);
  end
endmodule

// ===== verification/test_serial_port_command_hub.sv
`timescale 1ns/1ps
module test_serial_port_command_hub;
  import sph_pkg::*;
  typedef struct {int off; byte ch; bit hit;} sph_row_s;
  logic                  clock = 1'b0;
  logic                  rst = 1'b1;
  logic [REG_AW-1:0]     reg_addr = '0;
  logic [7:0]            reg_wdata = '0;
  logic                  reg_we = 1'b0;
  logic                  reg_re = 1'b0;
  logic [7:0]            reg_rdata;
  logic [7:0]            hrx_data;
  logic                  hrx_valid;
  logic                  hrx_ready;
  logic [7:0]            htx_data;
  logic                  htx_valid;
  logic                  htx_ready;
  logic [NPORT-1:0][7:0] dev_rx_data = '0;
  logic [NPORT-1:0]      dev_rx_valid = '0;
  logic [NPORT-1:0]      dev_rx_ready;
  logic [7:0]            dev_tx_data;
  logic [PORT_W-1:0]     dev_tx_port;
  logic                  dev_tx_valid;
  logic                  dev_tx_ready = 1'b0;
  logic [7:0]            dq_data[$];
  logic [PORT_W-1:0]     dq_port[$];
  int                    err_total = 0;
  int                    cmp_count = 0;
  logic [7:0]            ma = 8'hf9;
  logic [7:0]            d0;
  logic [7:0]            d1;
  string                 s;
  // module address f9 puts the last port on ff; off 7 wraps to 00
  sph_row_s              rows[9] = '{'{0, "a", 1}, '{1, "b", 1}, '{2, "c", 1},
    '{3, "d", 1}, '{4, "e", 1}, '{5, "f", 1}, '{6, "g", 1}, '{7, "h", 0}, '{-1, "i", 0}};

  always #12.5 clock = ~clock;

  sph_core #(.GAP_CYC(50)) u_dut (
    .clock         (clock),
    .rst           (rst),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_we        (reg_we),
    .reg_re        (reg_re),
    .reg_rdata     (reg_rdata),
    .host_rx_data  (hrx_data),
    .host_rx_valid (hrx_valid),
    .host_rx_ready (hrx_ready),
    .host_tx_data  (htx_data),
    .host_tx_valid (htx_valid),
    .host_tx_ready (htx_ready),
    .dev_rx_data   (dev_rx_data),
    .dev_rx_valid  (dev_rx_valid),
    .dev_rx_ready  (dev_rx_ready),
    .dev_tx_data   (dev_tx_data),
    .dev_tx_port   (dev_tx_port),
    .dev_tx_valid  (dev_tx_valid),
    .dev_tx_ready  (dev_tx_ready)
  );

  sph_host_model u_host (
    .clock    (clock),
    .rx_data  (hrx_data),
    .rx_valid (hrx_valid),
    .rx_ready (hrx_ready),
    .tx_data  (htx_data),
    .tx_valid (htx_valid),
    .tx_ready (htx_ready)
  );

  // device-side sink stalls every other cycle so held bytes get exercised
  always @(posedge clock)
  begin
    dev_tx_ready <= ~dev_tx_ready;
    if (dev_tx_valid && dev_tx_ready)
    begin
      dq_data.push_back(dev_tx_data);
      dq_port.push_back(dev_tx_port);
    end
  end

  task automatic close_out();
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask

  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clock);
    reg_we    <= 1'b0;
    @(posedge clock);
  endtask

  task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clock);
    reg_re   <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
    @(posedge clock);
  endtask

  // one device record, each byte held until its port takes it
  task automatic dev_send(input int p, input string r);
    foreach (r[i])
    begin
      dev_rx_data[p]  <= r[i];
      dev_rx_valid[p] <= 1'b1;
      do @(negedge clock); while (!dev_rx_ready[p]);
      @(posedge clock);
    end
    dev_rx_valid[p] <= 1'b0;
    dev_rx_data[p]  <= ~r[r.len()-1];
    @(posedge clock);
  endtask

  // bounded wait, then a quiet spell so extra or repeated bytes show up
  task automatic expect_host(input string e);
    int n;
    n = 0;
    while (u_host.got_q.size() < e.len() && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    repeat (40) @(posedge clock);
    chk(16'(u_host.got_q.size()), 16'(e.len()));
    foreach (e[i])
      if (i < u_host.got_q.size())
        chk(16'(u_host.got_q[i]), 16'(e[i]));
    u_host.got_q.delete();
  endtask

  task automatic ask(input string f, input string e);
    u_host.send(f);
    expect_host(e);
  endtask

  task automatic expect_dev(input string e, input int p);
    repeat (60) @(posedge clock);
    chk(16'(dq_data.size()), 16'(e.len()));
    foreach (e[i])
      if (i < dq_data.size())
        chk({5'h00, dq_port[i], dq_data[i]}, {5'h00, 3'(p), 8'(e[i])});
    dq_data.delete();
    dq_port.delete();
  endtask

  function automatic string ck(input string f);
    logic [7:0] sum;
    sum = 8'h00;
    foreach (f[i])
      sum += 8'(f[i]);
    return $sformatf("%02X", sum);
  endfunction

  // watchdog well beyond the under three thousand cycles the sequence needs
  initial
  begin
    repeat (30000) @(posedge clock);
    err_total++;
    close_out();
  end

  initial
  begin
    do_reset();
    reg_rd(REG_MADDR, d0);
    chk(16'(d0), 16'(MADDR_RST));
    reg_rd(REG_PDELIM, d0);
    chk(16'(d0), 16'(PDELIM_RST));
    reg_rd(3'h7, d0);
    chk(16'(d0), 16'h0000);
    reg_wr(REG_DROPS, 8'h55);
    reg_rd(REG_DROPS, d0);
    chk(16'(d0), 16'h0000);
    reg_wr(REG_MADDR, ma);
    reg_wr(REG_PDELIM, 8'h23);
    // pass-through to every port, then two addresses just outside the range
    foreach (rows[i])
    begin
      reg_rd(REG_DROPS, d0);
      u_host.send($sformatf("%c%02X%c\r", 8'h23, 8'(ma + rows[i].off), rows[i].ch));
      expect_dev(rows[i].hit ? $sformatf("%c\r", rows[i].ch) : "", rows[i].off);
      reg_rd(REG_DROPS, d1);
      chk(16'(d1), 16'(d0 + (rows[i].hit ? 8'h00 : 8'h01)));
    end
    // default mode: records queue up, each read once, then nothing
    dev_send(2, "ab\r");
    dev_send(2, "cd\r");
    reg_rd(REG_STATUS, d0);
    chk(16'(d0), 16'h0004);
    ask("$FBU\r", "ab\r");
    ask("$FBU\r", "cd\r");
    ask("$FBU\r", "");
    ask("$FBUR\r", "N/A\r");
    // latest mode keeps only the newest record; no end character, idle gap ends frames
    reg_wr(REG_CFG, 8'h0e);
    dev_send(1, "ab\r");
    dev_send(1, "yz\r");
    ask("$FAU", "yz");
    // prefix on, LF terminator, one record each from ports 0 and 4
    reg_wr(REG_CFG, 8'h14);
    dev_send(0, "q\r");
    dev_send(4, "z\r");
    ask("$F9UA\n", "F9q\nFDz\n");
    // checksum on, CR LF ends: a wrong sum is dropped and counted
    reg_wr(REG_CFG, 8'h03);
    dev_send(3, "m\r");
    s = "$FCU";
    reg_rd(REG_DROPS, d0);
    ask({s, "00\r\n"}, "");
    reg_rd(REG_DROPS, d1);
    chk(16'(d1), 16'(d0 + 8'h01));
    ask({s, ck(s), "\r\n"}, "m\r\n");
    // forwarding and prefix on, one record from port 5, host only listens and stalls
    reg_wr(REG_CFG, 8'h30);
    u_host.slow <= 1'b1;
    dev_send(5, "hi\r");
    expect_host("FEhi\r");
    u_host.slow <= 1'b0;
    reg_wr(REG_CFG, 8'h00);
    // fill one port buffer until it refuses
    s = "";
    repeat (BUF_DEPTH) s = {s, "k"};
    dev_send(6, s);
    @(negedge clock);
    chk(16'(dev_rx_ready[6]), 16'h0000);
    @(posedge clock);
    // second reset in mid-run clears settings and buffers
    do_reset();
    chk(16'(dev_rx_ready), 16'h007f);
    reg_rd(REG_CFG, d0);
    chk(16'(d0), 16'(CFG_RST));
    ask("$01U\r", "");
    close_out();
  end
endmodule
